// ### design/scc_pkg.sv
// Constants, field positions and helper functions of the serial frame CRC block
package scc_pkg;

    // Frame geometry
    localparam int         WR_LEN      = 21;
    localparam int         RD_LEN      = 22;
    localparam logic [4:0] LAST_BIT    = 5'h1f;
    localparam int         WR_CRC_LSB  = 3;
    localparam int         RD_CRC_LSB  = 2;
    localparam int         ACK_BIT     = 10;
    localparam int         BCAST_BIT   = 12;
    localparam int         DEV_LSB     = 27;
    localparam int         REG_LSB     = 21;
    localparam int         DATA_LSB    = 13;
    localparam logic [2:0] WR_PATTERN  = 3'b010;
    localparam logic [7:0] CRC_POLY    = 8'h2f;
    localparam logic [7:0] CRC_INIT    = 8'h00;

    // Register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] PAY_OFS    = 12'h004;
    localparam logic [11:0] STAT_OFS   = 12'h008;
    localparam logic [11:0] LASTWR_OFS = 12'h00c;
    localparam logic [3:0]  REGS_PAGE  = 4'h1;

    // Control fields and reset values
    localparam int          CTRL_PASS  = 0;
    localparam int          CTRL_AUTO  = 1;
    localparam int          CTRL_ADDR  = 2;
    localparam int          CTRL_RDREG = 8;
    localparam logic [13:0] CTRL_RST   = 14'h0;
    localparam logic [20:0] PAY_RST    = 21'h0;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLV   = 2'b10;

    // CRC over the top n bits of a frame, n at most RD_LEN, highest bit first
    function automatic logic [7:0] scc_crc(input logic [31:0] w, input int n);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < RD_LEN; i++)
        begin
            if (i < n)
                c = {c[6:0], w[31-i]} ^ (c[7] ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Device address travels LSB first
    function automatic logic [4:0] scc_rev5(input logic [4:0] a);
        return {a[0], a[1], a[2], a[3], a[4]};
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] scc_merge(input logic [31:0] o, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    // Word inside the 64-entry register page
    function automatic logic scc_regs_hit(input logic [11:0] a);
        return (a[11:8] == REGS_PAGE) && (a[1:0] == 2'b00);
    endfunction

endpackage

// ### design/scc_top.sv
// Serial frame CRC check: link-side shifter and AXI4-Lite register side
`timescale 1ns/1ns

module scc_link
    import scc_pkg::*;
(
    // Link pins, all timed by the serial clock
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        chain_in,
    output logic             sdo,
    // From the register side
    input  wire logic        arst_n,
    input  wire logic        pass,
    input  wire logic [31:0] own,
    input  wire logic        own_tog,
    // To the register side
    output logic [31:0]      wr_word,
    output logic             wr_tog
);
    typedef struct packed {
        logic        rs_m, rs_s, pm, ps, tm, ts, td;
        logic [31:0] hold;
        logic [4:0]  cnt;
        logic [31:0] rx, ch, tx;
        logic        sdo;
        logic [31:0] wr_word;
        logic        wr_tog;
    } scc_link_state_t;

    scc_link_state_t s;
    scc_link_state_t n;
    logic            frame_end;
    logic [31:0]     wr_full;
    logic [31:0]     up;
    logic [7:0]      up_crc;
    logic            crc_bad;
    logic [31:0]     fwd;
    logic [31:0]     next_frame;

    // Whole frames only; a partial frame is dropped when select rises
    assign frame_end  = !cs_n && (s.cnt == LAST_BIT);
    assign wr_full    = {s.rx[30:0], sdi};
    assign up         = {s.ch[30:0], chain_in};
    assign up_crc     = scc_crc(up, RD_LEN);
    assign crc_bad    = up_crc != up[RD_CRC_LSB +: 8];
    // Upstream frame with its check bits replaced on a mismatch
    assign fwd        = crc_bad ? {up[31:10], ~up_crc, up[1:0]} : up;
    assign next_frame = s.ps ? fwd : s.hold;

    // Next state of the link side
    always_comb
    begin
        n      = s;
        n.rs_m = arst_n;
        n.rs_s = s.rs_m;
        n.pm   = pass;
        n.ps   = s.pm;
        n.tm   = own_tog;
        n.ts   = s.tm;
        n.td   = s.ts;
        // Word is stable once its toggle has come through
        if (s.ts != s.td)
            n.hold = own;
        if (!cs_n)
        begin
            n.rx  = wr_full;
            n.ch  = up;
            n.tx  = {s.tx[30:0], 1'b0};
            n.sdo = s.tx[31];
            n.cnt = s.cnt + 5'h01;
            if (frame_end)
            begin
                n.wr_word = wr_full;
                n.wr_tog  = !s.wr_tog;
                n.tx      = {next_frame[30:0], 1'b0};
                n.sdo     = next_frame[31];
            end
        end
        else
        begin
            n.cnt = 5'h00;
        end
        if (!s.rs_s)
        begin
            n.hold    = 32'h00000000;
            n.cnt     = 5'h00;
            n.rx      = 32'h00000000;
            n.ch      = 32'h00000000;
            n.tx      = 32'h00000000;
            n.sdo     = 1'b0;
            n.wr_word = 32'h00000000;
            n.wr_tog  = 1'b0;
        end
    end

    // Link state register
    always_ff @(posedge sclk)
    begin
        s <= n;
    end

    assign sdo     = s.sdo;
    assign wr_word = s.wr_word;
    assign wr_tog  = s.wr_tog;

    // Checks on the link side
    default clocking lcb @(posedge sclk);
    endclocking
    default disable iff (!s.rs_s);

    chain_inv_a: assert property (frame_end && s.ps && crc_bad |=> s.tx[10:3] == ~$past(up_crc))
        else $error("chain CRC not inverted");
    chain_keep_a: assert property (frame_end && s.ps && !crc_bad |=> s.sdo == $past(up[31])
                                   && s.tx[10:3] == $past(up[9:2]))
        else $error("clean chain frame altered");
    wr_handoff_a: assert property (frame_end |=> s.wr_tog != $past(s.wr_tog)
                                   && s.wr_word == $past(wr_full))
        else $error("write word not handed over");
    chain_bad_c: cover property (frame_end && s.ps && crc_bad);

endmodule

module scc_top
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        chain_in,
    output logic             sdo
);
    import scc_pkg::*;

    typedef struct packed {
        logic             aw, w;
        logic [11:0]      awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             awready, wready, bvalid;
        logic [1:0]       bresp;
        logic             arready, rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic [13:0]      ctrl;
        logic [20:0]      pay;
        logic             ack, crc_err, pat_err;
        logic [31:0]      last_wr;
        logic [63:0][7:0] regs;
        logic             wt_m, wt_s, wt_d;
        logic [31:0]      own;
        logic             own_tog;
    } scc_top_state_t;

    scc_top_state_t s;
    scc_top_state_t n;
    logic [31:0]    wr_word;
    logic           wr_tog;
    logic           commit, crc_ok, pat_ok, wok, addressed;
    logic [5:0]     rd_sel;
    logic [20:0]    pay_eff;
    logic [31:0]    frame_raw;
    logic [31:0]    own_frame;

    // Link side lives on the serial clock
    scc_link u_link (
        .sclk     (sclk),
        .cs_n     (cs_n),
        .sdi      (sdi),
        .chain_in (chain_in),
        .sdo      (sdo),
        .arst_n   (aresetn),
        .pass     (s.ctrl[CTRL_PASS]),
        .own      (s.own),
        .own_tog  (s.own_tog),
        .wr_word  (wr_word),
        .wr_tog   (wr_tog)
    );

    // Received write is checked here; the word is held long after its toggle
    assign commit    = s.wt_s != s.wt_d;
    assign crc_ok    = scc_crc(wr_word, WR_LEN) == wr_word[WR_CRC_LSB +: 8];
    assign pat_ok    = wr_word[2:0] == WR_PATTERN;
    assign wok       = crc_ok && pat_ok;
    // Broadcast frames carry address zero, so only the flag is looked at
    assign addressed = wr_word[BCAST_BIT]
                       || (scc_rev5(wr_word[DEV_LSB +: 5]) == s.ctrl[CTRL_ADDR +: 5]);

    // Outgoing read frame: auto register frame or software payload
    assign rd_sel    = s.ctrl[CTRL_RDREG +: 6];
    assign pay_eff   = s.ctrl[CTRL_AUTO]
                       ? {scc_rev5(s.ctrl[CTRL_ADDR +: 5]), rd_sel, s.regs[rd_sel], 2'b00}
                       : s.pay;
    assign frame_raw = {pay_eff, s.ack, 10'h0};
    assign own_frame = {frame_raw[31:10], scc_crc(frame_raw, RD_LEN), 2'b00};

    // Next state: write result, bus slave, outgoing frame
    always_comb
    begin
        n      = s;
        n.wt_m = wr_tog;
        n.wt_s = s.wt_m;
        n.wt_d = s.wt_s;
        if (commit)
        begin
            n.crc_err = !crc_ok;
            n.pat_err = !pat_ok;
            n.ack     = wok;
            n.last_wr = wr_word;
            if (wok && addressed)
                n.regs[wr_word[REG_LSB +: 6]] = wr_word[DATA_LSB +: 8];
        end
        // Write address and data may come in either order
        if (s.bvalid && bready)
            n.bvalid = 1'b0;
        if (awvalid && s.awready)
        begin
            n.aw     = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && s.wready)
        begin
            n.w     = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (n.aw && n.w && !n.bvalid)
        begin
            n.aw     = 1'b0;
            n.w      = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            case (n.awaddr)
                CTRL_OFS: n.ctrl = 14'(scc_merge({18'h0, s.ctrl}, n.wdata, n.wstrb));
                PAY_OFS: n.pay = 21'(scc_merge({11'h0, s.pay}, n.wdata, n.wstrb));
                STAT_OFS, LASTWR_OFS: n.bresp = RESP_OKAY;
                default:
                begin
                    // Link registers are written only by frames
                    if (!scc_regs_hit(n.awaddr))
                        n.bresp = RESP_SLV;
                end
            endcase
        end
        n.awready = !n.aw && !n.bvalid;
        n.wready  = !n.w && !n.bvalid;
        // Read channel, one beat at a time
        if (s.rvalid && rready)
            n.rvalid = 1'b0;
        if (arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            case (araddr)
                CTRL_OFS: n.rdata = {18'h0, s.ctrl};
                PAY_OFS: n.rdata = {11'h0, s.pay};
                STAT_OFS: n.rdata = {29'h0, s.pat_err, s.crc_err, s.ack};
                LASTWR_OFS: n.rdata = s.last_wr;
                default:
                begin
                    n.rdata = 32'h00000000;
                    if (scc_regs_hit(araddr))
                        n.rdata = {24'h000000, s.regs[araddr[7:2]]};
                    else
                        n.rresp = RESP_SLV;
                end
            endcase
        end
        n.arready = !n.rvalid;
        // Toggle flips with the word; the link takes the word three of its edges later
        n.own = own_frame;
        if (own_frame != s.own)
            n.own_tog = !s.own_tog;
        if (!aresetn)
        begin
            n      = '0;
            n.ctrl = CTRL_RST;
            n.pay  = PAY_RST;
        end
    end

    // Register side state
    always_ff @(posedge aclk)
    begin
        s <= n;
    end

    assign awready = s.awready;
    assign wready  = s.wready;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = s.arready;
    assign rvalid  = s.rvalid;
    assign rresp   = s.rresp;
    assign rdata   = s.rdata;

    // Checks on the register side
    default clocking acb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    bad_wr_keep_a: assert property (commit && !wok |=> s.regs == $past(s.regs))
        else $error("rejected write changed a register");
    good_wr_store_a: assert property (commit && wok && addressed
                                      |=> s.regs[$past(wr_word[26:21])] == $past(wr_word[20:13]))
        else $error("accepted write not stored");
    ack_track_a: assert property (commit |=> s.ack == $past(wok))
        else $error("ack does not follow write check");
    pattern_rej_a: assert property (commit && !pat_ok |=> !s.ack)
        else $error("bad pattern acknowledged");
    own_crc_a: assert property (s.own[9:2] == scc_crc(s.own, RD_LEN))
        else $error("read frame CRC wrong");
    own_low_a: assert property (s.own[1:0] == 2'b00)
        else $error("read frame low bits not zero");
    own_ack_a: assert property ($rose(s.ack) |=> s.own[ACK_BIT] && s.own_tog != $past(s.own_tog))
        else $error("ack not placed in read frame");
    axi_wr_resp_a: assert property (awvalid && s.awready && wvalid && s.wready |=> s.bvalid)
        else $error("write response late");
    axi_rd_resp_a: assert property (arvalid && s.arready |=> s.rvalid && !s.arready)
        else $error("read response late");
    good_wr_c: cover property (commit && wok && addressed);
    bad_wr_c: cover property (commit && !crc_ok);
    rd_beat_c: cover property (s.rvalid && rready);

endmodule

// ### sim/scc_host_model.sv
// Host model on the serial link: frames writes out and captures the read frame
`timescale 1ns/1ns

module scc_host_model (
    // Link outputs
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    output logic      chain_in,
    // Link input
    input  wire logic sdo
);
    // Idle link, clock stopped
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        chain_in = 1'b0;
    end

    // Free ticks with select high, so reset and settings reach the link
    task automatic reset_ticks();
        repeat (4)
        begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask

    // One 32-edge frame, top bit first; sclk stands still outside it
    task automatic frame(input logic [31:0] wr, input logic [31:0] ch, output logic [31:0] rd);
        #53 cs_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            sdi = wr[i];
            chain_in = ch[i];
            #80 rd[i] = sdo;
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        // Released lines show the inverse, never a stale level
        #40 cs_n = 1'b1;
        sdi = ~sdi;
        chain_in = ~chain_in;
        #400;
    endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench: AXI4-Lite register side and serial frame CRC behaviour
`timescale 1ns/1ns

module tb_top;
    import scc_pkg::*;

    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_frame;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        sclk, cs_n, sdi, chain_in, sdo;
    int          fail_count, num_checks;
    localparam logic [31:0] GOOD_RD = 32'h814cd518;

    // Register clock, 40 ns period
    always #20 aclk = ~aclk;

    scc_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .chain_in(chain_in), .sdo(sdo));

    scc_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .chain_in(chain_in), .sdo(sdo));

    // Bit-serial reference, written apart from the design's own helper
    function automatic logic [7:0] ref_crc(input logic [31:0] w, input int n);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            fb = c[7];
            c = {c[6], c[5], c[4] ^ fb, c[3], c[2] ^ fb, c[1] ^ fb, c[0] ^ fb, w[31-i] ^ fb};
        end
        return c;
    endfunction

    // Expected read frame from payload and ack
    function automatic logic [31:0] mk_rd(input logic [20:0] p, input logic ack);
        logic [31:0] w;
        w = {p, ack, 10'h0};
        return {w[31:10], ref_crc(w, 22), 2'b00};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A wait that ran out ends the run
    task automatic give_up();
        fail_count++;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                done = 1'b1;
                bready <= 1'b0;
                chk_resp(bresp, exp);
            end
        end
        if (!done)
            give_up();
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                done = 1'b1;
                rready <= 1'b0;
                chk_word(rdata, d);
                chk_resp(rresp, exp);
            end
        end
        if (!done)
            give_up();
    endtask

    // Reset values, unmapped place, read-only place
    task automatic t_regs();
        axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
        axi_rd(PAY_OFS, 32'h0, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        axi_rd(12'h800, 32'h0, RESP_SLV);
        axi_wr(12'h800, 32'h1, RESP_SLV);
        axi_wr(STAT_OFS, 32'h7, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        $display("test regs done");
    endtask

    // Good write for another device: acked, not stored
    task automatic t_accept();
        axi_wr(CTRL_OFS, 32'h4, RESP_OKAY);
        axi_wr(PAY_OFS, 32'h10299a, RESP_OKAY);
        host.frame(32'h01a1828a, 32'h0, rd_frame);
        axi_rd(STAT_OFS, 32'h1, RESP_OKAY);
        axi_rd(LASTWR_OFS, 32'h01a1828a, RESP_OKAY);
        axi_rd(12'h134, 32'h0, RESP_OKAY);
        $display("test accept done");
    endtask

    // Data altered after the CRC was made: discarded
    task automatic t_crc_reject();
        host.frame(32'h81a183a2 ^ 32'h001fe000, 32'h0, rd_frame);
        chk_word(rd_frame, mk_rd(21'h10299a, 1'b0));
        axi_rd(STAT_OFS, 32'h2, RESP_OKAY);
        axi_rd(12'h134, 32'h0, RESP_OKAY);
        $display("test crc reject done");
    endtask

    // Good CRC, wrong low pattern: discarded
    task automatic t_pattern_reject();
        host.frame(32'h81a183a3, 32'h0, rd_frame);
        chk_word(rd_frame, GOOD_RD);
        axi_rd(STAT_OFS, 32'h4, RESP_OKAY);
        axi_rd(12'h134, 32'h0, RESP_OKAY);
        $display("test pattern reject done");
    endtask

    // Chain forwarding, broadcast write, corrupted frame from above
    task automatic t_chain();
        axi_wr(CTRL_OFS, 32'h5, RESP_OKAY);
        host.frame(32'h81a183a2, GOOD_RD, rd_frame);
        axi_rd(12'h134, 32'hc, RESP_OKAY);
        host.frame(32'h03a0546a, GOOD_RD ^ 32'h4, rd_frame);
        chk_word(rd_frame, GOOD_RD);
        axi_rd(12'h174, 32'h2, RESP_OKAY);
        host.frame(32'hf800030a, 32'h0, rd_frame);
        chk_word(rd_frame, {GOOD_RD[31:10], ~ref_crc(GOOD_RD, 22), 2'b00});
        $display("test chain done");
    endtask

    // Auto register frame: own address reversed, register index, contents, ack
    task automatic t_auto();
        axi_wr(CTRL_OFS, 32'hd06, RESP_OKAY);
        host.frame(32'hf800030a, 32'h0, rd_frame);
        host.frame(32'hf800030a, 32'h0, rd_frame);
        chk_word(rd_frame, mk_rd({5'h10, 6'h0d, 8'h0c, 2'b00}, 1'b1));
        $display("test auto done");
    endtask

    // Main sequence
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'hf;
        fail_count = 0;
        num_checks = 0;
        fork
            host.reset_ticks();
        join_none
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        host.reset_ticks();
        t_accept();
        t_crc_reject();
        t_pattern_reject();
        t_chain();
        t_auto();
        conclude();
    end
endmodule
